// ==== verilog/msw_cfg.svh ====
`ifndef MSW_CFG_SVH
`define MSW_CFG_SVH

// ----------------------------------------------------------------
// command codes on the host command port
// ----------------------------------------------------------------
`define MSW_CMD_READ_COND   8'h14
`define MSW_CMD_READ_IO     8'h15
`define MSW_CMD_CLEAR_COND  8'h3F

// ----------------------------------------------------------------
// data register that carries the condition word in its upper half
// ----------------------------------------------------------------
`define MSW_REG_IDX_COND    8'h03

// ----------------------------------------------------------------
// servo cycle timing
// ----------------------------------------------------------------
`define MSW_SERVO_PERIOD_NS 120000
`define MSW_CLK_PERIOD_NS   10

// ----------------------------------------------------------------
// field positions of the latch vector; the condition word holds latch bits 7-1 at bits 14-8
// ----------------------------------------------------------------
`define MSW_LAT_INDEX       0
`define MSW_LAT_MOVE_ERR    1
`define MSW_LAT_HOLD_ERR    2
`define MSW_LAT_HALT        3
`define MSW_LAT_STOP_FOUND  4
`define MSW_LAT_WAIT_DONE   5
`define MSW_LAT_OVER_VOLT   6
`define MSW_LAT_LOW_VOLT    7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MSW_IO_WORD_RST     16'h0000
`define MSW_RSP_DATA_RST    16'h0000
`define MSW_REG_DATA_RST    32'h0000_0000

`endif

// ==== verilog/msw_pkg.sv ====
package msw_pkg;

    // ------------------------------------------------------------
    // response sequencer states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RSP_IDLE = 2'b01,  // ready for a command
        RSP_SEND = 2'b10   // answer on the port this cycle
    } msw_rsp_state_t;

    // ------------------------------------------------------------
    // state of one sticky flag
    // ------------------------------------------------------------
    typedef struct packed {
        logic q;           // flag value
    } msw_latch_state_t;

    // ------------------------------------------------------------
    // state of the status bank top
    // ------------------------------------------------------------
    typedef struct packed {
        msw_rsp_state_t state;     // command sequencer
        logic [15:0]    rsp_data;  // answer word
        logic           rsp_err;   // unknown command flag
        logic [15:0]    io_word;   // servo-cycle snapshot of line status
        logic [2:0]     idx_pend;  // index events waiting for next tick
        logic [13:0]    tick_cnt;  // servo cycle down counter
        logic [31:0]    reg_data;  // data register read answer
        logic           reg_ack;   // data register read answered
        logic           reg_hit;   // index was the condition register
    } msw_top_state_t;

endpackage

// ==== verilog/msw_sync2.sv ====
`timescale 1ns/10ps

// ----------------------------------------------------------------
// two flop synchroniser for asynchronous pin levels
// ----------------------------------------------------------------
module msw_sync2 #(
    parameter int WIDTH = 7
) (
    input  wire logic             mclk_i,   // system clock
    input  wire logic             reset_i,  // synchronous reset, high
    input  wire logic [WIDTH-1:0] async_i,  // raw pin levels
    output logic      [WIDTH-1:0] sync_o    // levels in the clock domain
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;  // first stage, read only by second
        logic [WIDTH-1:0] sync;  // second stage
    } msw_sync_state_t;

    msw_sync_state_t st_ff;   // registered state
    msw_sync_state_t nxt_st;  // next state

    // shift the pins through both stages
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.meta = async_i;
        nxt_st.sync = st_ff.meta;
    end

    // idle lines read high, so reset to all ones
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_ff <= '{meta: '1, sync: '1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_o = st_ff.sync;

endmodule

// ==== verilog/msw_latch_bit.sv ====
`timescale 1ns/10ps

// ----------------------------------------------------------------
// one sticky condition flag; a set beats any clear
// ----------------------------------------------------------------
module msw_latch_bit (
    input  wire logic mclk_i,    // system clock
    input  wire logic reset_i,   // synchronous reset, high
    input  wire logic set_i,     // condition seen this cycle
    input  wire logic clr_i,     // clear command accepted
    input  wire logic auto_clr_i,// hardware clear, e.g. next move
    output logic      q_o        // flag value
);

    msw_pkg::msw_latch_state_t st_ff;   // registered state
    msw_pkg::msw_latch_state_t nxt_st;  // next state

    // set first so an event in the clear cycle is never lost
    always_comb begin
        nxt_st = st_ff;
        if (set_i) begin
            nxt_st.q = 1'b1;
        end else if (clr_i || auto_clr_i) begin
            nxt_st.q = 1'b0;
        end
    end

    // flag register
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_ff <= '{q: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q_o = st_ff.q;

endmodule

// ==== verilog/msw_top.sv ====
`timescale 1ns/10ps
`include "msw_cfg.svh"

module msw_top #(
    parameter int SERVO_CYCLES = `MSW_SERVO_PERIOD_NS / `MSW_CLK_PERIOD_NS
) (
    input  wire logic        mclk_i,            // system clock, 100 MHz
    input  wire logic        reset_i,           // synchronous reset, high
    input  wire logic [6:0]  io_line_i,         // pins, bit 0 is line 1
    input  wire logic        delay_counting_i,  // delay counter running
    input  wire logic        hold_err_i,        // holding error limit exceeded
    input  wire logic        move_err_i,        // moving error limit exceeded
    input  wire logic        over_temp_i,       // sensor reports over temperature
    input  wire logic        traj_active_i,     // trajectory generator busy
    input  wire logic        ext_index_i,       // external encoder index event
    input  wire logic        int_index_i,       // internal encoder index event
    input  wire logic        sel_index_i,       // selected encoder index event
    input  wire logic        low_volt_i,        // low voltage fault event
    input  wire logic        over_volt_i,       // over voltage fault event
    input  wire logic        wait_expired_i,    // wait delay timer expired
    input  wire logic        stop_found_i,      // stop input found in a move
    input  wire logic        move_start_i,      // a new move begins
    input  wire logic        abrupt_stop_i,     // abrupt stop command received
    input  wire logic        calc_neg_i,        // last calculation negative
    input  wire logic        calc_pos_i,        // last calculation positive
    input  wire logic        calc_zero_i,       // last calculation zero
    input  wire logic        cmd_valid_i,       // host command present
    input  wire logic [7:0]  cmd_code_i,        // host command number
    output logic             cmd_ready_o,       // command can be taken
    output logic             rsp_valid_o,       // answer present, one cycle
    output logic [15:0]      rsp_data_o,        // answer word
    output logic             rsp_err_o,         // command not known
    input  wire logic        reg_rd_valid_i,    // data register read request
    input  wire logic [7:0]  reg_rd_idx_i,      // data register number
    input  wire logic [15:0] reg3_low_i,        // lower half of register 3
    output logic             reg_rd_ack_o,      // read answered, one cycle
    output logic             reg_rd_hit_o,      // number was register 3
    output logic [31:0]      reg_rd_data_o      // register contents
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam logic [13:0] TICK_LOAD = 14'(SERVO_CYCLES - 1);  // counter reload

    msw_pkg::msw_top_state_t st_ff;    // registered state
    msw_pkg::msw_top_state_t nxt_st;   // next state
    logic [6:0]  io_sync;              // synchronised pin levels
    logic [7:0]  lat_set;              // sticky flag set events
    logic [7:0]  lat_auto;             // sticky flag hardware clears
    logic [7:0]  lat_q;                // sticky flag values
    logic        clr_cmd;              // clear command accepted this cycle
    logic        cmd_take;             // command accepted this cycle
    logic        tick;                 // last cycle of a servo period
    logic [2:0]  idx_now;              // pending plus new index events
    logic [15:0] cond_word;            // live condition word

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    msw_sync2 #(
        .WIDTH (7)
    ) u_sync (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .async_i (io_line_i),
        .sync_o  (io_sync)
    );

    // ------------------------------------------------------------
    // sticky condition flags
    // ------------------------------------------------------------
    // event sources per flag position
    always_comb begin
        lat_set                      = 8'h00;
        lat_auto                     = 8'h00;
        lat_set[`MSW_LAT_INDEX]      = ext_index_i | int_index_i | sel_index_i;
        lat_set[`MSW_LAT_MOVE_ERR]   = move_err_i;
        lat_set[`MSW_LAT_HOLD_ERR]   = hold_err_i;
        lat_set[`MSW_LAT_HALT]       = abrupt_stop_i;
        lat_set[`MSW_LAT_STOP_FOUND] = stop_found_i;
        lat_set[`MSW_LAT_WAIT_DONE]  = wait_expired_i;
        lat_set[`MSW_LAT_OVER_VOLT]  = over_volt_i;
        lat_set[`MSW_LAT_LOW_VOLT]   = low_volt_i;
        lat_auto[`MSW_LAT_STOP_FOUND] = move_start_i;
    end

    // one flag instance per latched bit
    for (genvar gi = 0; gi < 8; gi++) begin : g_lat
        msw_latch_bit u_lat (
            .mclk_i     (mclk_i),
            .reset_i    (reset_i),
            .set_i      (lat_set[gi]),
            .clr_i      (clr_cmd),
            .auto_clr_i (lat_auto[gi]),
            .q_o        (lat_q[gi])
        );
    end

    // ------------------------------------------------------------
    // condition word assembly
    // ------------------------------------------------------------
    // reserved bit 15 is a constant zero, nothing can set it
    assign cond_word = {1'b0,
                        lat_q[7:1],
                        ~over_temp_i,
                        io_sync[2:0],
                        calc_neg_i, calc_pos_i, calc_zero_i,
                        lat_q[`MSW_LAT_INDEX]};

    // ------------------------------------------------------------
    // handshake decode
    // ------------------------------------------------------------
    assign cmd_ready_o = (st_ff.state == msw_pkg::RSP_IDLE);
    assign cmd_take    = cmd_valid_i && cmd_ready_o;
    assign clr_cmd     = cmd_take && (cmd_code_i == `MSW_CMD_CLEAR_COND);
    assign tick        = (st_ff.tick_cnt == 14'h0000);
    assign idx_now     = st_ff.idx_pend | {ext_index_i, int_index_i, sel_index_i};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.reg_ack = 1'b0;
        nxt_st.reg_hit = 1'b0;
        // servo period counter, free running
        if (tick) begin
            nxt_st.tick_cnt = TICK_LOAD;
        end else begin
            nxt_st.tick_cnt = st_ff.tick_cnt - 14'h0001;
        end
        // line status snapshot; index events held until the tick so
        // each shows for exactly one servo period
        if (tick) begin
            nxt_st.io_word  = {io_sync[6:3],
                               1'b0,
                               delay_counting_i,
                               hold_err_i, move_err_i,
                               ~over_temp_i,
                               io_sync[2:0],
                               traj_active_i,
                               idx_now};
            nxt_st.idx_pend = 3'h0;
        end else begin
            nxt_st.idx_pend = idx_now;
        end
        // command sequencer
        case (st_ff.state)
            msw_pkg::RSP_IDLE: begin
                if (cmd_valid_i) begin
                    nxt_st.state   = msw_pkg::RSP_SEND;
                    nxt_st.rsp_err = 1'b0;
                    if (cmd_code_i == `MSW_CMD_READ_COND) begin
                        nxt_st.rsp_data = cond_word;
                    end else if (cmd_code_i == `MSW_CMD_READ_IO) begin
                        nxt_st.rsp_data = st_ff.io_word;
                    end else if (cmd_code_i == `MSW_CMD_CLEAR_COND) begin
                        nxt_st.rsp_data = `MSW_RSP_DATA_RST;   // plain ack
                    end else begin
                        nxt_st.rsp_data = `MSW_RSP_DATA_RST;
                        nxt_st.rsp_err  = 1'b1;                // unknown code
                    end
                end
            end
            msw_pkg::RSP_SEND: begin
                // answer shown for one cycle, no back-pressure from host
                nxt_st.state = msw_pkg::RSP_IDLE;
            end
            default: begin
                nxt_st.state = msw_pkg::RSP_IDLE;
            end
        endcase
        // data register read port, answered next cycle
        if (reg_rd_valid_i) begin
            nxt_st.reg_ack = 1'b1;
            if (reg_rd_idx_i == `MSW_REG_IDX_COND) begin
                nxt_st.reg_hit  = 1'b1;
                nxt_st.reg_data = {cond_word, reg3_low_i};
            end else begin
                nxt_st.reg_data = `MSW_REG_DATA_RST;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_ff <= '{state:    msw_pkg::RSP_IDLE,
                       rsp_data: `MSW_RSP_DATA_RST,
                       rsp_err:  1'b0,
                       io_word:  `MSW_IO_WORD_RST,
                       idx_pend: 3'h0,
                       tick_cnt: TICK_LOAD,
                       reg_data: `MSW_REG_DATA_RST,
                       reg_ack:  1'b0,
                       reg_hit:  1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rsp_valid_o   = (st_ff.state == msw_pkg::RSP_SEND);
    assign rsp_data_o    = st_ff.rsp_data;
    assign rsp_err_o     = st_ff.rsp_err && rsp_valid_o;
    assign reg_rd_ack_o  = st_ff.reg_ack;
    assign reg_rd_hit_o  = st_ff.reg_hit;
    assign reg_rd_data_o = st_ff.reg_data;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);

    AST_HIGH_LINES: assert property (tick |=> st_ff.io_word[15:12] == $past(io_sync[6:3]))
        else $error("line status bits 15-12 do not follow lines 7-4");
    AST_LOW_LINES: assert property (cond_word[6:4] == io_sync[2:0]
                                    and (tick |=> st_ff.io_word[6:4] == $past(io_sync[2:0])))
        else $error("bits 6-4 do not follow lines 3-1");
    AST_DELAY_BIT: assert property (tick |=> st_ff.io_word[10] == $past(delay_counting_i))
        else $error("delay counter bit wrong");
    AST_LIVE_ERR: assert property (tick |=> st_ff.io_word[9] == $past(hold_err_i)
                                   && st_ff.io_word[8] == $past(move_err_i))
        else $error("live error limit bits wrong");
    AST_ERR_LATCH: assert property (hold_err_i && move_err_i |=> cond_word[9:8] == 2'h3)
        else $error("error limit flags did not latch");
    AST_TEMP_LOW: assert property (cmd_take && cmd_code_i == `MSW_CMD_READ_COND && over_temp_i
                                   |=> !rsp_data_o[7])
        else $error("temperature bit not low in over temperature");
    AST_TRAJ: assert property (tick |=> st_ff.io_word[3] == $past(traj_active_i))
        else $error("trajectory bit wrong");
    AST_INDEX_PULSE: assert property (tick && idx_now[2] ##1 !tick[*2] |-> st_ff.io_word[2])
        else $error("external index pulse not held for the servo cycle");
    AST_CLEAR: assert property (clr_cmd && (lat_set == 8'h00) |=> lat_q == 8'h00)
        else $error("clear command left a flag set");
    AST_SET_WINS: assert property (clr_cmd && wait_expired_i |=> cond_word[12])
        else $error("set lost against clear");
    AST_READ_COND: assert property (cmd_take && cmd_code_i == `MSW_CMD_READ_COND
                                    |=> rsp_valid_o && rsp_data_o == $past(cond_word) ##1 !rsp_valid_o)
        else $error("condition word read answered wrongly");
    AST_REG3: assert property (reg_rd_valid_i && reg_rd_idx_i == `MSW_REG_IDX_COND
                               |=> reg_rd_hit_o && reg_rd_data_o[31:16] == $past(cond_word))
        else $error("register 3 upper half is not the condition word");
    AST_VOLT: assert property (low_volt_i && over_volt_i |=> cond_word[14:13] == 2'h3)
        else $error("voltage flags did not latch");
    AST_STOP_AUTO: assert property (move_start_i && !stop_found_i |=> !cond_word[11])
        else $error("stop found flag not cleared by new move");
    AST_HALT: assert property (abrupt_stop_i |=> cond_word[10])
        else $error("abrupt stop flag did not latch");
    AST_SIGN: assert property (cmd_take && cmd_code_i == `MSW_CMD_READ_COND
                               |=> rsp_data_o[3] == $past(calc_neg_i) && rsp_data_o[2] == $past(calc_pos_i)
                                   && rsp_data_o[1] == $past(calc_zero_i))
        else $error("calculation sign bits wrong");
    AST_INDEX_LATCH: assert property (sel_index_i |=> cond_word[0])
        else $error("index flag did not latch");
    AST_REFRESH: assert property (!tick |=> $stable(st_ff.io_word))
        else $error("line status word changed between servo ticks");
    AST_RESERVED: assert property (!cond_word[15] && !st_ff.io_word[11])
        else $error("reserved bit set");
    AST_HOLD_ONLY: assert property (hold_err_i |=> cond_word[9])
        else $error("holding error flag did not latch");
    AST_MOVE_ONLY: assert property (move_err_i |=> cond_word[8])
        else $error("moving error flag did not latch");
    AST_LOW_VOLT: assert property (low_volt_i |=> cond_word[14])
        else $error("low voltage flag did not latch");
    AST_OVER_VOLT: assert property (over_volt_i |=> cond_word[13])
        else $error("over voltage flag did not latch");
    AST_IDX_ANY: assert property (ext_index_i || int_index_i |=> cond_word[0])
        else $error("index flag ignored an encoder");
    AST_IDX_DROP: assert property (tick && idx_now == 3'h0 |=> st_ff.io_word[2:0] == 3'h0)
        else $error("index pulse outlived its servo cycle");

    COV_READ_COND: cover property (cmd_take && cmd_code_i == `MSW_CMD_READ_COND ##1 rsp_valid_o);
    COV_CLEAR_SET: cover property (clr_cmd && lat_set != 8'h00);
    COV_INDEX_TICK: cover property (tick && st_ff.idx_pend != 3'h0);
    COV_REG3: cover property (reg_rd_valid_i && reg_rd_idx_i == `MSW_REG_IDX_COND);
    COV_SET_WINS: cover property (clr_cmd && wait_expired_i);

endmodule

// ==== tb/msw_host_model.sv ====
`timescale 1ns/10ps

// ----------------------------------------------------------------
// host side of the status command port
// ----------------------------------------------------------------
module msw_host_model (
    input  wire logic        mclk_i,       // system clock
    input  wire logic        cmd_ready_i,  // device can take a command
    input  wire logic        rsp_valid_i,  // answer present, one cycle
    input  wire logic [15:0] rsp_data_i,   // answer word
    input  wire logic        rsp_err_i,    // command not known
    output logic             cmd_valid_o,  // command present
    output logic [7:0]       cmd_code_o    // command number
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_code_o  = 8'h00;
    end
    // hold the command until taken; the answer is looked at in its only cycle
    task automatic send(input logic [7:0] code, output logic [15:0] data, output logic err);
        @(posedge mclk_i);
        cmd_valid_o <= 1'b1;
        cmd_code_o  <= code;
        do @(posedge mclk_i); while (cmd_ready_i !== 1'b1);
        cmd_valid_o <= 1'b0;
        // idle code is inverted so a stale code never looks current
        cmd_code_o  <= ~code;
        @(posedge mclk_i);
        data = (rsp_valid_i === 1'b1) ? rsp_data_i : 16'hDEAD;
        err  = rsp_err_i;
    endtask
endmodule

// ==== tb/motion_status_words_test.sv ====
`timescale 1ns/10ps

// ----------------------------------------------------------------
// status word bank bench
// ----------------------------------------------------------------
module motion_status_words_test;
    localparam int SERVO = 9;                     // multiple of 3 so index reads count evenly
    localparam int BIT_POS [8] = '{14, 13, 12, 11, 10, 9, 8, 0};
    logic        mclk = 1'b0;                     // system clock
    logic        rst  = 1'b1;                     // synchronous reset
    logic [6:0]  io   = 7'h7F;                    // pins, idle high
    logic [7:0]  ev   = 8'h00;                    // latch set events
    logic [6:0]  lvl  = 7'h01;                    // pos, delay, temp, traj, move, neg, zero
    logic [1:0]  ix   = 2'h0;                     // internal, selected index events
    logic        cv, cr, rv, re, ak, ht, gerr;    // command and register handshakes
    logic [7:0]  cc;                              // command code
    logic [15:0] rd, got;                         // answer words
    logic        rq = 1'b0;                       // register read request
    logic [7:0]  ri = 8'h00;                      // register number
    logic [15:0] lo = 16'h0000;                   // lower half of register 3
    logic [31:0] rdat;                            // register answer
    int          miscompares = 0, checks_done = 0, cycles = 0, n;

    always #5 mclk = ~mclk;
    msw_top #(.SERVO_CYCLES(SERVO)) dut (.mclk_i(mclk), .reset_i(rst), .io_line_i(io),
        .delay_counting_i(lvl[5]), .hold_err_i(ev[5]), .move_err_i(ev[6]), .over_temp_i(lvl[4]),
        .traj_active_i(lvl[3]), .ext_index_i(ev[7]), .int_index_i(ix[1]), .sel_index_i(ix[0]),
        .low_volt_i(ev[0]), .over_volt_i(ev[1]), .wait_expired_i(ev[2]), .stop_found_i(ev[3]),
        .move_start_i(lvl[2]), .abrupt_stop_i(ev[4]), .calc_neg_i(lvl[1]), .calc_pos_i(lvl[6]),
        .calc_zero_i(lvl[0]), .cmd_valid_i(cv), .cmd_code_i(cc), .cmd_ready_o(cr), .rsp_valid_o(rv),
        .rsp_data_o(rd), .rsp_err_o(re), .reg_rd_valid_i(rq), .reg_rd_idx_i(ri), .reg3_low_i(lo),
        .reg_rd_ack_o(ak), .reg_rd_hit_o(ht), .reg_rd_data_o(rdat));
    msw_host_model host (.mclk_i(mclk), .cmd_ready_i(cr), .rsp_valid_i(rv), .rsp_data_i(rd),
        .rsp_err_i(re), .cmd_valid_o(cv), .cmd_code_o(cc));

    task automatic tally_and_finish;
        if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rd_chk(input logic [7:0] code, input logic [15:0] e);
        host.send(code, got, gerr);
        chk({gerr, got}, {1'b0, e});
    endtask
    // each sticky flag sets from its own event and drops on clear
    task automatic test_latches;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            ev <= 8'(8'h01 << i);
            @(posedge mclk);
            ev <= 8'h00;
            rd_chk(8'h14, 16'h00F2 | 16'(16'h0001 << BIT_POS[i]));
            rd_chk(8'h3F, 16'h0000);
            rd_chk(8'h14, 16'h00F2);
        end
    endtask
    // a new move wipes the stop-found flag; a set outlives a clear in its cycle
    task automatic test_move_clear;
        @(posedge mclk);
        ev <= 8'h08;
        @(posedge mclk);
        ev <= 8'h00;
        lvl[2] <= 1'b1;
        @(posedge mclk);
        lvl[2] <= 1'b0;
        rd_chk(8'h14, 16'h00F2);
        ev <= 8'h04;
        rd_chk(8'h3F, 16'h0000);
        ev <= 8'h00;
        rd_chk(8'h14, 16'h10F2);
        rd_chk(8'h3F, 16'h0000);
    endtask
    // live fields other than the positive sign bit at non-idle values, seen after a servo refresh
    task automatic test_live_fields;
        @(posedge mclk);
        io  <= 7'h2A;
        ev  <= 8'h60;
        lvl <= 7'h3A;
        repeat (2 * SERVO + 4) @(posedge mclk);
        rd_chk(8'h15, 16'h5728);
        rd_chk(8'h14, 16'h0328);
        @(posedge mclk);
        io  <= 7'h7F;
        ev  <= 8'h00;
        lvl <= 7'h01;
        rd_chk(8'h3F, 16'h0000);
    endtask
    // an index pulse shows in the line word for one servo period only
    task automatic test_index(input logic [2:0] w);
        @(posedge mclk);
        {ev[7], ix} <= w;
        @(posedge mclk);
        {ev[7], ix} <= 3'h0;
        n = 0;
        repeat (4 * SERVO / 3) begin
            host.send(8'h15, got, gerr);
            n += int'(got[2:0] === w);
        end
        chk(40'(n), 40'(SERVO / 3));
        rd_chk(8'h14, 16'h00F3);
        rd_chk(8'h3F, 16'h0000);
    endtask
    // register 3 carries the condition word on top, back to back with a miss
    task automatic test_reg_read;
        @(posedge mclk);
        rq <= 1'b1;
        ri <= 8'h03;
        lo <= 16'hA5C3;
        lvl <= 7'h40;
        @(posedge mclk);
        ri <= 8'h04;
        @(posedge mclk);
        rq <= 1'b0;
        chk({ak, ht, rdat}, {2'b11, 16'h00F4, 16'hA5C3});
        @(posedge mclk);
        chk({ak, ht, rdat}, {2'b10, 32'h0000_0000});
        host.send(8'h77, got, gerr);
        chk({gerr, got}, {1'b1, 16'h0000});
    endtask

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rd_chk(8'h14, 16'h00F2);
        test_latches();
        test_move_clear();
        test_live_fields();
        test_index(3'h4);
        test_index(3'h2);
        test_index(3'h1);
        test_reg_read();
        tally_and_finish();
    end
endmodule
